// >>> remote_temp_limit_registers.sv
/*
 remote diode limit registers: high, low and critical limits, read and
 written through a byte-wide register port with one-cycle write strobe.
 assumes format-select and override bits arrive from the configuration
 registers held elsewhere, synchronous to ref_clk.
*/
// Behaviour
// - high limit is 11 bits: upper byte, lower bits 7:5; upper resets 0x55
// - high limit read unsigned or signed, chosen by format select bit
// - lower-byte bits 4:0 read zero and ignore writes
// - low limit 11 bits, signed, upper and lower reset to zero
// - critical limit is an 8-bit whole-degree value, default 110
// - critical write accepted only while override bit is clear, then held
// - format select clear: critical bit 7 is the sign
`timescale 1ns/1ns
module remote_temp_limit_registers
	import limit_regs_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	output logic      [DATA_W-1:0] reg_rdata,
	// configuration inputs
	input  wire logic              unsigned_format_select,
	input  wire logic              critical_limit_unlock,
	// limits as used by comparators
	output logic      [LIMIT_W:0]  high_limit_ext,
	output logic      [LIMIT_W:0]  low_limit_ext,
	output logic      [8:0]        critical_limit_ext
);
	logic [7:0]         high_limit_upper_bits;
	logic [LOWER_W-1:0] high_limit_lower_bits;
	logic [7:0]         low_limit_upper_bits;
	logic [LOWER_W-1:0] low_limit_lower_bits;
	logic [7:0]         critical_limit;
	logic               wr_hu;
	logic               wr_lu;
	logic               wr_hl;
	logic               wr_ll;
	logic               wr_cr;
	logic [DATA_W-1:0]  nxt_rdata;
	logic [DATA_W-1:0]  rdata_ff;
	logic [LIMIT_W:0]   nxt_high_ext;
	logic [LIMIT_W:0]   nxt_low_ext;
	logic [8:0]         nxt_crit_ext;
	logic [LIMIT_W:0]   high_ext_ff;
	logic [LIMIT_W:0]   low_ext_ff;
	logic [8:0]         crit_ext_ff;

	always_comb begin
		wr_hu = reg_wr && (reg_addr == ADDR_HIGH_UPPER || reg_addr == ADDR_HIGH_UPPER2);
		wr_lu = reg_wr && (reg_addr == ADDR_LOW_UPPER || reg_addr == ADDR_LOW_UPPER2);
		wr_hl = reg_wr && reg_addr == ADDR_HIGH_LOWER;
		wr_ll = reg_wr && reg_addr == ADDR_LOW_LOWER;
		wr_cr = reg_wr && reg_addr == ADDR_CRIT && !critical_limit_unlock;
	end

	limit_byte_reg #(.W(8), .RST_V(RST_HIGH_UPPER)) u_high_upper (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_hu),
		.wr_data (reg_wdata),
		.value   (high_limit_upper_bits)
	);
	limit_byte_reg #(.W(LOWER_W), .RST_V({LOWER_PAD, RST_LOWER_BITS})) u_high_lower (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_hl),
		.wr_data (reg_wdata[LOWER_MSB:LOWER_LSB]),
		.value   (high_limit_lower_bits)
	);
	limit_byte_reg #(.W(8), .RST_V(RST_LOW_UPPER)) u_low_upper (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_lu),
		.wr_data (reg_wdata),
		.value   (low_limit_upper_bits)
	);
	limit_byte_reg #(.W(LOWER_W), .RST_V({LOWER_PAD, RST_LOWER_BITS})) u_low_lower (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_ll),
		.wr_data (reg_wdata[LOWER_MSB:LOWER_LSB]),
		.value   (low_limit_lower_bits)
	);
	limit_byte_reg #(.W(8), .RST_V(RST_CRIT)) u_crit (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (wr_cr),
		.wr_data (reg_wdata),
		.value   (critical_limit)
	);

	// read mux, registered
	always_comb begin
		case (reg_addr)
			ADDR_HIGH_UPPER, ADDR_HIGH_UPPER2: nxt_rdata = high_limit_upper_bits;
			ADDR_LOW_UPPER, ADDR_LOW_UPPER2:   nxt_rdata = low_limit_upper_bits;
			ADDR_HIGH_LOWER: nxt_rdata = {high_limit_lower_bits, LOWER_PAD};
			ADDR_LOW_LOWER:  nxt_rdata = {low_limit_lower_bits, LOWER_PAD};
			ADDR_CRIT:       nxt_rdata = critical_limit;
			default:         nxt_rdata = READ_UNMAPPED;
		endcase
	end

	// 12-bit high/low and 9-bit critical views; high and critical zero-extended when format select set
	always_comb begin
		if (unsigned_format_select) begin
			nxt_high_ext = {1'b0, high_limit_upper_bits, high_limit_lower_bits};
			nxt_crit_ext = {1'b0, critical_limit};
		end else begin
			nxt_high_ext = {high_limit_upper_bits[7], high_limit_upper_bits,
				high_limit_lower_bits};
			nxt_crit_ext = {critical_limit[7], critical_limit};
		end
		nxt_low_ext = {low_limit_upper_bits[7], low_limit_upper_bits,
			low_limit_lower_bits};
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff    <= READ_UNMAPPED;
			high_ext_ff <= '0;
			low_ext_ff  <= '0;
			crit_ext_ff <= '0;
		end else begin
			rdata_ff    <= nxt_rdata;
			high_ext_ff <= nxt_high_ext;
			low_ext_ff  <= nxt_low_ext;
			crit_ext_ff <= nxt_crit_ext;
		end
	end

	assign reg_rdata          = rdata_ff;
	assign high_limit_ext     = high_ext_ff;
	assign low_limit_ext      = low_ext_ff;
	assign critical_limit_ext = crit_ext_ff;

	property p_high_reset;
		@(posedge ref_clk) $rose(rst_b) |-> high_limit_upper_bits == RST_HIGH_UPPER;
	endproperty
	a_high_reset: assert property (p_high_reset) else $error("high limit reset wrong");

	property p_high_write;
		@(posedge ref_clk) disable iff (!rst_b)
		wr_hu |=> high_limit_upper_bits == $past(reg_wdata);
	endproperty
	a_high_write: assert property (p_high_write) else $error("high upper not stored");

	property p_lower_pad;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_addr == ADDR_HIGH_LOWER || reg_addr == ADDR_LOW_LOWER)
			|=> reg_rdata[LOWER_LSB-1:0] == LOWER_PAD;
	endproperty
	a_lower_pad: assert property (p_lower_pad) else $error("reserved bits nonzero");

	property p_low_signed;
		@(posedge ref_clk) disable iff (!rst_b)
		##1 low_limit_ext[LIMIT_W] == $past(low_limit_upper_bits[7]);
	endproperty
	a_low_signed: assert property (p_low_signed) else $error("low limit sign wrong");

	property p_crit_locked;
		@(posedge ref_clk) disable iff (!rst_b)
		critical_limit_unlock |=> $stable(critical_limit);
	endproperty
	a_crit_locked: assert property (p_crit_locked) else $error("critical changed while locked");

	property p_crit_write;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ADDR_CRIT && !critical_limit_unlock)
			|=> critical_limit == $past(reg_wdata);
	endproperty
	a_crit_write: assert property (p_crit_write) else $error("critical write lost");

	property p_crit_sign;
		@(posedge ref_clk) disable iff (!rst_b)
		!unsigned_format_select |=> critical_limit_ext[8] == $past(critical_limit[7]);
	endproperty
	a_crit_sign: assert property (p_crit_sign) else $error("critical sign wrong");

	property p_crit_unsigned;
		@(posedge ref_clk) disable iff (!rst_b)
		unsigned_format_select |=> critical_limit_ext[8] == 1'b0;
	endproperty
	a_crit_unsigned: assert property (p_crit_unsigned) else $error("critical not unsigned");

	property p_high_fmt;
		@(posedge ref_clk) disable iff (!rst_b)
		unsigned_format_select |=> high_limit_ext[LIMIT_W] == 1'b0;
	endproperty
	a_high_fmt: assert property (p_high_fmt) else $error("high format wrong");

	property p_crit_reset;
		@(posedge ref_clk) $rose(rst_b) |-> critical_limit == RST_CRIT;
	endproperty
	a_crit_reset: assert property (p_crit_reset) else $error("critical reset wrong");
endmodule // remote_temp_limit_registers

// >>> limit_regs_pkg.sv
/*
 remote temperature limit register bank: offsets, reset values, field layout.
 assumes a byte-wide register port behind the two-wire management interface.
*/
package limit_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_HIGH_UPPER  = 8'h07;
	localparam logic [7:0] ADDR_HIGH_UPPER2 = 8'h0D;
	localparam logic [7:0] ADDR_LOW_UPPER   = 8'h08;
	localparam logic [7:0] ADDR_LOW_UPPER2  = 8'h0E;
	localparam logic [7:0] ADDR_HIGH_LOWER  = 8'h13;
	localparam logic [7:0] ADDR_LOW_LOWER   = 8'h14;
	localparam logic [7:0] ADDR_CRIT        = 8'h19;
	localparam logic [7:0] RST_HIGH_UPPER   = 8'h55;
	localparam logic [7:0] RST_LOW_UPPER    = 8'h00;
	localparam logic [2:0] RST_LOWER_BITS   = 3'h0;
	localparam logic [7:0] RST_CRIT         = 8'h6E;
	localparam int LOWER_MSB = 7;
	localparam int LOWER_LSB = 5;
	localparam int LOWER_W   = 3;
	localparam logic [4:0] LOWER_PAD = 5'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int LIMIT_W = 11;
endpackage

// >>> limit_byte_reg.sv
/*
 one writable limit field with reset value and write strobe.
 assumes a single synchronous clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module limit_byte_reg #(
	parameter int         W     = 8,
	parameter logic [7:0] RST_V = 8'h00
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// write side
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	// stored value
	output logic      [W-1:0] value
);
	logic [W-1:0] val_ff;
	logic [W-1:0] nxt_val;

	always_comb begin
		nxt_val = wr_en ? wr_data : val_ff;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			val_ff <= RST_V[W-1:0];
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign value = val_ff;
endmodule // limit_byte_reg

// >>> host_model.sv
/*
 host side model: drives the register port and the configuration bits.
 assumes ref_clk from the bench; it changes its outputs 1 ns after a rising edge.
*/
`timescale 1ns/1ns
module host_model
	import limit_regs_pkg::*;
(
	// clock
	input  wire logic              ref_clk,
	// register port
	output logic      [ADDR_W-1:0] reg_addr,
	output logic                   reg_wr,
	output logic      [DATA_W-1:0] reg_wdata,
	input  wire logic [DATA_W-1:0] reg_rdata,
	// configuration bits
	output logic                   unsigned_format_select,
	output logic                   critical_limit_unlock
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		unsigned_format_select = 1'b0;
		critical_limit_unlock = 1'b1;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		// data lines carry no meaning once the strobe drops
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		@(posedge ref_clk);
		#1;
		d = reg_rdata;
	endtask

	// format select, changed only from inside this model
	task automatic fmt(input logic v);
		unsigned_format_select = v;
	endtask

	// override cleared first, then the new value, then locked again
	task automatic crit(input logic [7:0] d);
		critical_limit_unlock = 1'b0;
		wr(ADDR_CRIT, d);
		critical_limit_unlock = 1'b1;
	endtask
endmodule // host_model

// >>> tb_top.sv
/*
 self-checking bench for the remote limit register bank.
 assumes host_model drives every design input except clock and reset.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	import limit_regs_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr;
	logic              reg_wr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic              ufs;
	logic              unlock;
	logic [LIMIT_W:0]  high_ext;
	logic [LIMIT_W:0]  low_ext;
	logic [8:0]        crit_ext;
	int                failures = 0;
	int                cmp_count = 0;

	always #2 ref_clk = ~ref_clk;

	remote_temp_limit_registers i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.unsigned_format_select(ufs), .critical_limit_unlock(unlock),
		.high_limit_ext(high_ext), .low_limit_ext(low_ext), .critical_limit_ext(crit_ext));
	host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .unsigned_format_select(ufs),
		.critical_limit_unlock(unlock));

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		`CHK("reg_rdata", e, d)
	endtask

	// let registered views settle
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		rc(ADDR_HIGH_UPPER, 8'h55);
		rc(ADDR_HIGH_UPPER2, 8'h55);
		rc(ADDR_HIGH_LOWER, 8'h00);
		rc(ADDR_LOW_UPPER, 8'h00);
		rc(ADDR_LOW_LOWER, 8'h00);
		rc(ADDR_CRIT, 8'h6E);
		`CHK("high_limit_ext", 12'h2A8, high_ext)
		$display("test reset done");
		i_host.wr(ADDR_HIGH_UPPER, 8'hC0);
		i_host.wr(ADDR_HIGH_LOWER, 8'hFF);
		rc(ADDR_HIGH_LOWER, 8'hE0);
		rc(ADDR_HIGH_UPPER2, 8'hC0);
		`CHK("high_limit_ext", 12'hE07, high_ext)
		i_host.fmt(1'b1);
		settle();
		`CHK("high_limit_ext", 12'h607, high_ext)
		$display("test high limit done");
		i_host.wr(ADDR_LOW_UPPER2, 8'h80);
		i_host.wr(ADDR_LOW_LOWER, 8'h3F);
		rc(ADDR_LOW_LOWER, 8'h20);
		rc(ADDR_LOW_UPPER, 8'h80);
		`CHK("low_limit_ext", 12'hC01, low_ext)
		$display("test low limit done");
		i_host.wr(ADDR_CRIT, 8'h90);
		rc(ADDR_CRIT, 8'h6E);
		i_host.crit(8'h90);
		rc(ADDR_CRIT, 8'h90);
		settle();
		`CHK("critical_limit_ext", 9'h090, crit_ext)
		i_host.fmt(1'b0);
		settle();
		`CHK("critical_limit_ext", 9'h190, crit_ext)
		i_host.crit(8'h7F);
		settle();
		`CHK("critical_limit_ext", 9'h07F, crit_ext)
		$display("test critical limit done");
		i_host.wr(8'h20, 8'hA5);
		rc(8'h20, READ_UNMAPPED);
		rc(ADDR_HIGH_UPPER, 8'hC0);
		$display("test unmapped done");
		@(posedge ref_clk);
		#1;
		rst_b = 1'b0;
		@(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		rc(ADDR_HIGH_UPPER, 8'h55);
		rc(ADDR_CRIT, 8'h6E);
		$display("test mid reset done");
		finish_test();
	end
endmodule // tb_top
